// ==== logic/xctx_pkg.sv ====
// Shared constants and types for the cross-context move unit
package xctx_pkg;
    localparam int DATA_W = 32;
    localparam int FP_W = 64;
    localparam int CTX_W = 4;
    localparam int VCPU_W = 2;
    localparam logic [5:0] OPC_MAJOR = 6'h08;
    localparam logic [5:0] FUNC_TO_CTX = 6'h27;
    localparam logic [5:0] FUNC_FROM_CTX = 6'h26;
    localparam logic [2:0] LOW_BITS = 3'h0;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RT_HI = 25;
    localparam int RT_LO = 21;
    localparam int RS_HI = 20;
    localparam int RS_LO = 16;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 11;
    localparam int U_BIT = 10;
    localparam int FUNC_HI = 9;
    localparam int FUNC_LO = 4;
    localparam int H_BIT = 3;
    localparam logic [4:0] SEL_GPR = 5'h00;
    localparam logic [4:0] SEL_ACC = 5'h01;
    localparam logic [4:0] SEL_FPR = 5'h02;
    localparam logic [4:0] SEL_FP_CONTROL_REG = 5'h03;
    localparam logic [4:0] SEL_C2D = 5'h04;
    localparam logic [4:0] SEL_C2C = 5'h05;
    localparam logic [4:0] RS_DSPCTL = 5'h10;
    localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    typedef enum logic [3:0] {
        DST_NONE, DST_CP0, DST_GPR, DST_LO, DST_HI, DST_ACX,
        DST_DSPCTL, DST_FPR, DST_FP_CONTROL_REG, DST_C2D, DST_C2C
    } dest_kind_t;
endpackage : xctx_pkg

// ==== logic/xctx_decode.sv ====
// Instruction field splitter and destination class decoder
`timescale 1ns/1ns
module xctx_decode
    import xctx_pkg::*;
(
    input wire logic [31:0] instr,
    output logic is_to,
    output logic is_from,
    output logic [4:0] rt,
    output logic [4:0] rs,
    output logic [4:0] sel,
    output logic u,
    output logic h,
    output xctx_pkg::dest_kind_t kind,
    output logic [1:0] acc_num
);
    logic frame_ok;
    always_comb
    begin
        frame_ok = (instr[OPC_HI:OPC_LO] == OPC_MAJOR)
            && (instr[2:0] == LOW_BITS);
        is_to = frame_ok && (instr[FUNC_HI:FUNC_LO] == FUNC_TO_CTX);
        is_from = frame_ok && (instr[FUNC_HI:FUNC_LO] == FUNC_FROM_CTX);
        rt = instr[RT_HI:RT_LO];
        rs = instr[RS_HI:RS_LO];
        sel = instr[SEL_HI:SEL_LO];
        u = instr[U_BIT];
        h = instr[H_BIT];
        acc_num = rs[3:2];
        kind = DST_NONE;
        if (!u)
            kind = DST_CP0;
        else if (sel == SEL_GPR)
            kind = DST_GPR;
        else if (sel == SEL_ACC)
        begin
            // rs bit 4 clear and low pair 0..2 selects an accumulator
            if (rs == RS_DSPCTL)
                kind = DST_DSPCTL;
            else if (!rs[4] && rs[1:0] == 2'h0)
                kind = DST_LO;
            else if (!rs[4] && rs[1:0] == 2'h1)
                kind = DST_HI;
            else if (!rs[4] && rs[1:0] == 2'h2)
                kind = DST_ACX;
        end
        else if (sel == SEL_FPR)
            kind = DST_FPR;
        else if (sel == SEL_FP_CONTROL_REG)
            kind = DST_FP_CONTROL_REG;
        else if (sel == SEL_C2D)
            kind = DST_C2D;
        else if (sel == SEL_C2C)
            kind = DST_C2C;
    end
endmodule : xctx_decode

// ==== logic/xctx_move.sv ====
// Cross-context register move execution unit
`timescale 1ns/1ns
module xctx_move
    import xctx_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic ISSUE,
    input wire logic [31:0] INSTR,
    input wire logic [31:0] RT_VALUE,
    input wire logic [4:0] RX,
    input wire logic CP0_ENABLED,
    input wire logic MT_PRESENT,
    input wire logic MULTI_VCPU_PRIVILEGE,
    input wire logic [xctx_pkg::CTX_W-1:0] TARGET_CONTEXT_INDEX,
    input wire logic [xctx_pkg::CTX_W-1:0] HIGHEST_CONTEXT_NUMBER,
    input wire logic [xctx_pkg::VCPU_W-1:0] OWN_BOUND_VCPU,
    input wire logic [xctx_pkg::VCPU_W-1:0] TARGET_BOUND_VCPU,
    input wire logic FP_SPLIT_MODE,
    input wire logic HAS_FPU,
    input wire logic HAS_DSP,
    input wire logic HAS_COP2,
    input wire logic READ_VALID,
    input wire logic [63:0] READ_DATA,
    output logic READ_REQ,
    output logic WRITE_REQ,
    output logic [xctx_pkg::CTX_W-1:0] ACC_CONTEXT,
    output logic [3:0] ACC_KIND,
    output logic [9:0] ACC_INDEX,
    output logic [2:0] ACC_SEL,
    output logic ACC_HIGH,
    output logic [31:0] WRITE_DATA,
    output logic RESULT_VALID,
    output logic [4:0] RESULT_RT,
    output logic [31:0] RESULT_DATA,
    output logic EXC_COP_UNUSABLE,
    output logic EXC_RESERVED,
    output logic BUSY
);
    import xctx_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_READ} state_t;

    logic is_to, is_from, u, h;
    logic [4:0] rt, rs, sel;
    logic [1:0] acc_num;
    dest_kind_t kind;

    xctx_decode u_dec (
        .instr(INSTR),
        .is_to(is_to),
        .is_from(is_from),
        .rt(rt),
        .rs(rs),
        .sel(sel),
        .u(u),
        .h(h),
        .kind(kind),
        .acc_num(acc_num)
    );

    state_t state_q, state_d;
    logic read_req_q, read_req_d, write_req_q, write_req_d;
    logic [CTX_W-1:0] ctx_q, ctx_d;
    logic [3:0] kind_q, kind_d;
    logic [9:0] index_q, index_d;
    logic [2:0] sel_q, sel_d;
    logic high_q, high_d, split_q, split_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic rvalid_q, rvalid_d, ecu_q, ecu_d, eri_q, eri_d;
    logic [4:0] rrt_q, rrt_d;
    logic denied, present;
    logic busy_q, busy_d;
    logic [31:0] picked;

    always_comb
    begin
        // Resource presence only; usable and dsp enable bits are not looked at
        present = 1'b1;
        if (kind == DST_NONE)
            present = 1'b0;
        else if (kind == DST_LO || kind == DST_HI || kind == DST_ACX
            || kind == DST_DSPCTL)
            present = HAS_DSP || (kind != DST_DSPCTL && acc_num == 2'h0);
        else if (kind == DST_FPR || kind == DST_FP_CONTROL_REG)
            present = HAS_FPU;
        else if (kind == DST_C2D || kind == DST_C2C)
            present = HAS_COP2;
        denied = (!MULTI_VCPU_PRIVILEGE
            && TARGET_BOUND_VCPU != OWN_BOUND_VCPU)
            || (TARGET_CONTEXT_INDEX > HIGHEST_CONTEXT_NUMBER);
        // only split mode and cop2 have a meaningful upper half
        if (high_q && (split_q || kind_q == 4'(DST_C2D)
            || kind_q == 4'(DST_C2C)))
            picked = READ_DATA[63:32];
        else
            picked = READ_DATA[31:0];
    end

    always_comb
    begin
        state_d = state_q;
        read_req_d = 1'b0;
        write_req_d = 1'b0;
        ctx_d = ctx_q;
        kind_d = kind_q;
        index_d = index_q;
        sel_d = sel_q;
        high_d = high_q;
        split_d = split_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        ecu_d = 1'b0;
        eri_d = 1'b0;
        rrt_d = rrt_q;
        case (state_q)
            IDLE:
                if (ISSUE && (is_to || is_from))
                begin
                    ctx_d = TARGET_CONTEXT_INDEX;
                    kind_d = 4'(kind);
                    index_d = {RX, rs};
                    sel_d = sel[2:0];
                    high_d = h;
                    split_d = HAS_FPU && FP_SPLIT_MODE;
                    wdata_d = RT_VALUE;
                    rrt_d = rt;
                    if (!MT_PRESENT)
                        eri_d = 1'b1;
                    else if (!CP0_ENABLED)
                        ecu_d = 1'b1;
                    else if (is_to)
                        write_req_d = !denied && present;
                    else if (denied)
                    begin
                        rdata_d = ALL_ONES;
                        rvalid_d = 1'b1;
                    end
                    else if (!present)
                    begin
                        // Unimplemented source reads all ones; allows it
                        rdata_d = ALL_ONES;
                        rvalid_d = 1'b1;
                    end
                    else
                    begin
                        // waits as long as the target holds READ_VALID off
                        read_req_d = 1'b1;
                        state_d = WAIT_READ;
                    end
                end
            WAIT_READ:
                if (READ_VALID)
                begin
                    rdata_d = picked;
                    // 32-bit sources already fill the word; ACX is sign-extended
                    // from the low 8 bits of READ_DATA to the full 32-bit result
                    if (kind_q == 4'(DST_ACX))
                        rdata_d = {{24{READ_DATA[7]}}, READ_DATA[7:0]};
                    rvalid_d = 1'b1;
                    state_d = IDLE;
                end
                else
                    read_req_d = 1'b1;
            default:
                state_d = IDLE;
        endcase
        // Registered so that BUSY leaves the block straight from a flop
        busy_d = (state_d != IDLE);
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q <= IDLE;
            read_req_q <= 1'b0;
            write_req_q <= 1'b0;
            ctx_q <= '0;
            kind_q <= '0;
            index_q <= '0;
            sel_q <= '0;
            high_q <= 1'b0;
            split_q <= 1'b0;
            wdata_q <= RESET_WORD;
            rdata_q <= RESET_WORD;
            rvalid_q <= 1'b0;
            ecu_q <= 1'b0;
            eri_q <= 1'b0;
            rrt_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            read_req_q <= read_req_d;
            write_req_q <= write_req_d;
            ctx_q <= ctx_d;
            kind_q <= kind_d;
            index_q <= index_d;
            sel_q <= sel_d;
            high_q <= high_d;
            split_q <= split_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            ecu_q <= ecu_d;
            eri_q <= eri_d;
            rrt_q <= rrt_d;
            busy_q <= busy_d;
        end
    end

    always_comb
    begin
        READ_REQ = read_req_q;
        WRITE_REQ = write_req_q;
        ACC_CONTEXT = ctx_q;
        ACC_KIND = kind_q;
        ACC_INDEX = index_q;
        ACC_SEL = sel_q;
        ACC_HIGH = high_q;
        WRITE_DATA = wdata_q;
        RESULT_VALID = rvalid_q;
        RESULT_RT = rrt_q;
        RESULT_DATA = rdata_q;
        EXC_COP_UNUSABLE = ecu_q;
        EXC_RESERVED = eri_q;
        BUSY = busy_q;
    end
endmodule : xctx_move

// ==== tb/xctx_move_asserts.sv ====
// Port-level checks for the cross-context move unit
`timescale 1ns/1ns
module xctx_move_chk
    import xctx_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic ISSUE,
    input wire logic [31:0] INSTR,
    input wire logic [31:0] RT_VALUE,
    input wire logic CP0_ENABLED,
    input wire logic MT_PRESENT,
    input wire logic MULTI_VCPU_PRIVILEGE,
    input wire logic [xctx_pkg::CTX_W-1:0] TARGET_CONTEXT_INDEX,
    input wire logic [xctx_pkg::CTX_W-1:0] HIGHEST_CONTEXT_NUMBER,
    input wire logic [xctx_pkg::VCPU_W-1:0] OWN_BOUND_VCPU,
    input wire logic [xctx_pkg::VCPU_W-1:0] TARGET_BOUND_VCPU,
    input wire logic READ_VALID,
    input wire logic READ_REQ,
    input wire logic WRITE_REQ,
    input wire logic [xctx_pkg::CTX_W-1:0] ACC_CONTEXT,
    input wire logic [31:0] WRITE_DATA,
    input wire logic RESULT_VALID,
    input wire logic [31:0] RESULT_DATA,
    input wire logic EXC_COP_UNUSABLE,
    input wire logic EXC_RESERVED,
    input wire logic BUSY
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    logic go, to_op, fr_op, ok, deny, plain;
    assign go = ISSUE && !BUSY && INSTR[31:26] == OPC_MAJOR
        && INSTR[2:0] == LOW_BITS;
    assign to_op = go && INSTR[9:4] == FUNC_TO_CTX;
    assign fr_op = go && INSTR[9:4] == FUNC_FROM_CTX;
    assign ok = MT_PRESENT && CP0_ENABLED;
    // Either access check alone is enough to refuse the move
    assign deny = TARGET_CONTEXT_INDEX > HIGHEST_CONTEXT_NUMBER
        || (!MULTI_VCPU_PRIVILEGE && OWN_BOUND_VCPU != TARGET_BOUND_VCPU);
    // CP0 and GPR destinations exist on every build
    assign plain = !INSTR[10] || INSTR[15:11] == SEL_GPR;
    rsvd_exc_a: assert property ((to_op || fr_op) && !MT_PRESENT
        |=> EXC_RESERVED && !EXC_COP_UNUSABLE) else $error("no reserved");
    cop_exc_a: assert property ((to_op || fr_op) && MT_PRESENT
        && !CP0_ENABLED |=> EXC_COP_UNUSABLE && !WRITE_REQ && !READ_REQ)
        else $error("no cop unusable");
    deny_wr_a: assert property (to_op && ok && deny
        |=> !WRITE_REQ && !READ_REQ && !RESULT_VALID)
        else $error("denied write issued");
    deny_rd_a: assert property (fr_op && ok && deny
        |=> RESULT_VALID && RESULT_DATA == ALL_ONES && !READ_REQ)
        else $error("denied read not all ones");
    wr_go_a: assert property (to_op && ok && !deny && plain
        |=> WRITE_REQ ##1 (!WRITE_REQ || $past(to_op)))
        else $error("write pulse wrong");
    wr_data_a: assert property (WRITE_REQ |-> WRITE_DATA ==
        $past(RT_VALUE) && ACC_CONTEXT == $past(TARGET_CONTEXT_INDEX))
        else $error("write data or context wrong");
    rd_done_a: assert property (READ_REQ && READ_VALID
        |=> RESULT_VALID && !READ_REQ && !BUSY) else $error("read end");
    rd_hold_a: assert property (READ_REQ && !READ_VALID
        |=> READ_REQ && BUSY) else $error("read request dropped");
    cover property (to_op && ok && !deny);
    cover property (READ_REQ && READ_VALID);
    cover property (fr_op && ok && deny);
    cover property (EXC_COP_UNUSABLE);
endmodule : xctx_move_chk
bind xctx_move xctx_move_chk u_chk (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the cross-context move unit
`timescale 1ns/1ns
module tb_top;
    import xctx_pkg::*;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic ISSUE = 1'b0;
    logic CP0_ENABLED = 1'b1;
    logic MT_PRESENT = 1'b1;
    logic MULTI_VCPU_PRIVILEGE = 1'b0;
    logic FP_SPLIT_MODE = 1'b1;
    logic HAS_FPU = 1'b1, HAS_DSP = 1'b1, HAS_COP2 = 1'b1;
    logic READ_VALID = 1'b0;
    logic [31:0] INSTR = 32'h0, RT_VALUE = 32'h0;
    logic [4:0] RX = 5'h15;
    logic [3:0] TARGET_CONTEXT_INDEX = 4'h1, HIGHEST_CONTEXT_NUMBER = 4'h3;
    logic [1:0] OWN_BOUND_VCPU = 2'h0, TARGET_BOUND_VCPU = 2'h0;
    logic [63:0] READ_DATA = 64'h0;
    logic READ_REQ, WRITE_REQ, ACC_HIGH, RESULT_VALID, EXC_COP_UNUSABLE;
    logic EXC_RESERVED, BUSY;
    logic [3:0] ACC_CONTEXT, ACC_KIND;
    logic [9:0] ACC_INDEX;
    logic [2:0] ACC_SEL;
    logic [31:0] WRITE_DATA, RESULT_DATA, got, rt_v;
    logic [4:0] RESULT_RT;
    logic [63:0] rd_v = 64'h11223344_8899AABB;
    int err_total = 0;
    int check_count = 0;
    int n_wr, n_rv, n_cu, n_ri;
    logic rq;
    xctx_move dut (.*);
    always #50 MCLK = ~MCLK;
    task automatic end_of_test();
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One instruction; the register file answers one cycle after a request
    task automatic run(input logic to, input logic u, input logic [4:0] sel,
        input logic [4:0] rs, input logic h);
        n_wr = 0;
        n_rv = 0;
        n_cu = 0;
        n_ri = 0;
        got = 32'h0;
        @(posedge MCLK);
        ISSUE <= 1'b1;
        RT_VALUE <= rt_v;
        READ_DATA <= rd_v;
        INSTR <= {OPC_MAJOR, 5'h07, rs, sel, u,
            to ? FUNC_TO_CTX : FUNC_FROM_CTX, h, LOW_BITS};
        @(posedge MCLK);
        ISSUE <= 1'b0;
        repeat (6)
        begin
            #1;
            n_wr += (WRITE_REQ === 1'b1);
            n_rv += (RESULT_VALID === 1'b1);
            n_cu += (EXC_COP_UNUSABLE === 1'b1);
            n_ri += (EXC_RESERVED === 1'b1);
            if (RESULT_VALID === 1'b1)
                got = RESULT_DATA;
            // Request seen settled, answered at the next edge
            rq = (READ_REQ === 1'b1);
            @(posedge MCLK);
            READ_VALID <= rq;
        end
        if (BUSY !== 1'b0)
        begin
            err_total++;
            $display("[FAIL] %0t unit stuck busy", $time);
            end_of_test();
        end
    endtask : run
    task automatic t_write();
        rt_v = 32'h800000F1;
        run(1'b1, 1'b1, SEL_GPR, 5'h0B, 1'b0);
        chk(32'(n_wr), 32'h1);
        chk(WRITE_DATA, rt_v);
        chk(32'(ACC_KIND), 32'(DST_GPR));
        chk(32'(ACC_INDEX[4:0]), 32'h0B);
        chk(32'(ACC_CONTEXT), 32'h1);
        run(1'b1, 1'b0, 5'h03, 5'h0C, 1'b1);
        chk(32'({ACC_KIND, ACC_SEL, ACC_HIGH}), 32'({DST_CP0, 4'h7}));
    endtask : t_write
    task automatic t_read();
        run(1'b0, 1'b1, SEL_FPR, 5'h02, 1'b1);
        chk(got, 32'h11223344);
        run(1'b0, 1'b1, SEL_GPR, 5'h03, 1'b0);
        chk(got, 32'h8899AABB);
        chk(32'(RESULT_RT), 32'h07);
        run(1'b0, 1'b1, SEL_ACC, 5'h02, 1'b0);
        chk(got, 32'hFFFFFFBB);
        run(1'b0, 1'b1, SEL_C2D, 5'h04, 1'b1);
        chk(got, 32'h11223344);
        chk(32'(ACC_INDEX), 32'({5'h15, 5'h04}));
        run(1'b0, 1'b1, SEL_ACC, RS_DSPCTL, 1'b0);
        chk(32'(ACC_KIND), 32'(DST_DSPCTL));
        chk(got, 32'h8899AABB);
        run(1'b0, 1'b1, SEL_ACC, 5'h0D, 1'b0);
        chk(32'(ACC_KIND), 32'(DST_HI));
        run(1'b0, 1'b1, SEL_ACC, 5'h03, 1'b0);
        chk(got, ALL_ONES);
        run(1'b0, 1'b1, SEL_FP_CONTROL_REG, 5'h1F, 1'b0);
        chk(32'(ACC_KIND), 32'(DST_FP_CONTROL_REG));
        chk(got, 32'h8899AABB);
        run(1'b0, 1'b1, 5'h06, 5'h01, 1'b0);
        chk(got, ALL_ONES);
        FP_SPLIT_MODE <= 1'b0;
        run(1'b0, 1'b1, SEL_FPR, 5'h05, 1'b0);
        chk(got, 32'h8899AABB);
        FP_SPLIT_MODE <= 1'b1;
    endtask : t_read
    task automatic t_deny();
        @(posedge MCLK);
        TARGET_BOUND_VCPU <= 2'h1;
        run(1'b1, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(32'(n_wr), 32'h0);
        run(1'b0, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(got, ALL_ONES);
        TARGET_BOUND_VCPU <= 2'h0;
        TARGET_CONTEXT_INDEX <= 4'h4;
        run(1'b0, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(got, ALL_ONES);
        TARGET_CONTEXT_INDEX <= 4'h3;
        run(1'b0, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(got, 32'h8899AABB);
        HAS_COP2 <= 1'b0;
        run(1'b1, 1'b1, SEL_C2D, 5'h01, 1'b0);
        chk(32'(n_wr), 32'h0);
        HAS_COP2 <= 1'b1;
    endtask : t_deny
    task automatic t_exc();
        @(posedge MCLK);
        CP0_ENABLED <= 1'b0;
        run(1'b0, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(32'({n_cu[3:0], n_rv[3:0]}), 32'h10);
        MT_PRESENT <= 1'b0;
        run(1'b1, 1'b1, SEL_GPR, 5'h01, 1'b0);
        chk(32'({n_ri[3:0], n_wr[3:0]}), 32'h10);
        CP0_ENABLED <= 1'b1;
        MT_PRESENT <= 1'b1;
    endtask : t_exc
    initial
    begin
        repeat (12) @(posedge MCLK);
        #1;
        chk(32'({READ_REQ, WRITE_REQ, RESULT_VALID, BUSY}), 32'h0);
        @(posedge MCLK);
        RST_N <= 1'b1;
        t_write();
        t_read();
        t_deny();
        t_exc();
        end_of_test();
    end
endmodule : tb_top
